// >>> common/irq_agg_pkg.sv
package irq_agg_pkg;

   // Source and bank geometry.
   localparam int NUM_SOURCES = 24;
   localparam int GROUP_WIDTH = 8;
   localparam int NUM_GROUPS = 3;
   localparam int ADDR_WIDTH = 4;
   localparam int DATA_WIDTH = 8;

   // Bit ranges of the three banks inside the 24-bit source vector.
   localparam int HIGH_LSB = 16;
   localparam int MID_LSB = 8;
   localparam int LOW_LSB = 0;

   // Register offsets on the plain register port.
   localparam logic [3:0] OFFS_HIGH_FLAGS = 4'h0;
   localparam logic [3:0] OFFS_MID_FLAGS = 4'h1;
   localparam logic [3:0] OFFS_LOW_FLAGS = 4'h2;
   localparam logic [3:0] OFFS_HIGH_ENABLES = 4'h3;
   localparam logic [3:0] OFFS_MID_ENABLES = 4'h4;
   localparam logic [3:0] OFFS_LOW_ENABLES = 4'h5;
   localparam logic [3:0] OFFS_PRIORITY_CODE = 4'h6;
   localparam logic [3:0] OFFS_LEVEL_SUMMARY = 4'h7;
   localparam logic [3:0] OFFS_EVENT_STATUS = 4'h8;
   localparam logic [3:0] OFFS_EVENT_MASK = 4'h9;

   // Field positions of the level summary and of the event registers.
   localparam int HIGH_POS = 2;
   localparam int MID_POS = 1;
   localparam int LOW_POS = 0;

   // Reset values.
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   localparam logic [7:0] PRIORITY_RESET = 8'hFF;
   localparam logic [7:0] NO_PENDING_CODE = 8'hFF;
   localparam logic [2:0] SUMMARY_RESET = 3'h0;
   localparam logic [2:0] EVENT_RESET = 3'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Cycles from a source rising to its level request rising.
   localparam int REQUEST_LATENCY = 1;

endpackage

// >>> common/irq_edge_if.sv
`timescale 1ns/100ps
// Carries the one-cycle rising-edge pulses from the sampler to the core.
interface irq_edge_if #(parameter int WIDTH = 24);
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] level;
   modport sampler (output rise, output level);
   modport consumer (input rise, input level);
endinterface

// >>> design/irq_source_sampler.sv
`timescale 1ns/100ps
module irq_source_sampler #(
   parameter int WIDTH = 24
) (
   input wire logic sys_clk_in, // System clock.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] sources_in, // Same-clock source levels.
   irq_edge_if.sampler edges // Edge pulses towards the core.
);

   logic [WIDTH-1:0] prev;
   logic [WIDTH-1:0] next_prev;

   // The sources come from peripherals on this clock, so no synchroniser
   // stands here; adding one would break the one-cycle request latency.
   always_comb
   begin
      next_prev = sources_in; // [R10]
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         prev <= '0;
      else
         prev <= next_prev;
   end

   // A rise is the present sample high while the last one was low.
   assign edges.rise = sources_in & ~prev; // [R10]
   assign edges.level = prev;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);

   chk_rise_from_samples: assert property ( // [R10]
      edges.rise[0] |=> prev[0] && !$past(prev[0]))
      else $error("edge pulse not backed by two samples");

endmodule

// >>> design/three_level_irq_aggregator.sv
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
// Functional notes
// [R01] Three level requests: high, mid and low group, each source one level.
// [R02] The processor serves level zero, then one, then two.
// [R03] A flag sets only on an enabled rising source edge.
// [R04] Writing one to a flag bit clears that flag.
// [R05] Writing zero to a flag bit leaves that flag alone.
// [R06] Software also retires the level inside the processor itself.
// [R07] Reset clears every flag and every level request.
// [R08] Priority code gives highest latched source, 0xFF when none.
// [R09] Level summary shows per group whether any flag is latched.
// [R10] Sources are sampled on the system clock; edges use those samples.
// [R11] A request rises and stays latched when a qualifying source rises.
// [R12] A level request rises exactly one cycle after the source edge.
// [R13] Priority code equals the source number, 0x00 to 0x17.
// [R14] High bank holds sources 23-16, mid 15-8, low 7-0.
// [R15] Three read-write enable registers, one bit per source, reset zero.
// [R16] Summary: high in bit 2, mid bit 1, low bit 0, rest zero.
// [R17] Priority code register is read-only and resets to all ones.
// [R18] A new edge in the same cycle as its clear keeps the flag set.
module three_level_irq_aggregator #(
   parameter int NUM_SOURCES = irq_agg_pkg::NUM_SOURCES
) (
   input wire logic sys_clk_in, // System clock, 100 MHz.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic [NUM_SOURCES-1:0] irq_sources_in, // Peripheral sources.
   input wire logic [3:0] reg_addr_in, // Register offset.
   input wire logic [7:0] reg_wdata_in, // Write data.
   input wire logic reg_wr_in, // Write strobe, one cycle.
   input wire logic reg_rd_in, // Read strobe, one cycle.
   output logic [7:0] reg_rdata_out, // Read data, cycle after the strobe.
   output logic cpu_level_zero_request_out, // High group request.
   output logic cpu_level_one_request_out, // Mid group request.
   output logic cpu_level_two_request_out, // Low group request.
   output logic block_irq_out // Unmasked event status pending.
);

   irq_edge_if #(.WIDTH(NUM_SOURCES)) edges ();

   // Source sampling and edge detection live in their own module.
   irq_source_sampler #(.WIDTH(NUM_SOURCES)) irq_source_sampler_inst (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .sources_in(irq_sources_in),
      .edges(edges.sampler)
   );

   // Returns the highest latched source number, or the idle code.
   function automatic logic [7:0] highest_code(
      input logic [NUM_SOURCES-1:0] v);
      logic [7:0] code;
      code = irq_agg_pkg::NO_PENDING_CODE;
      for (int i = 0; i < NUM_SOURCES; i++)
      begin
         if (v[i])
            code = 8'(i);
      end
      return code;
   endfunction

   // Folds the flag vector into per-group indicators, high in bit 2.
   function automatic logic [2:0] group_any(
      input logic [NUM_SOURCES-1:0] v);
      logic [2:0] g;
      g = '0;
      g[irq_agg_pkg::HIGH_POS] = |v[irq_agg_pkg::HIGH_LSB +: 8];
      g[irq_agg_pkg::MID_POS] = |v[irq_agg_pkg::MID_LSB +: 8];
      g[irq_agg_pkg::LOW_POS] = |v[irq_agg_pkg::LOW_LSB +: 8];
      return g;
   endfunction

   // Flag banks and enable banks, both as one 24-bit vector.
   logic [NUM_SOURCES-1:0] flags;
   logic [NUM_SOURCES-1:0] enables;
   logic [NUM_SOURCES-1:0] next_flags;
   logic [NUM_SOURCES-1:0] next_enables;
   logic [NUM_SOURCES-1:0] flag_set;
   logic [NUM_SOURCES-1:0] flag_clear;

   // Derived state kept in flip-flops so the outputs come from registers.
   logic [7:0] priority_code;
   logic [7:0] next_priority_code;
   logic [2:0] summary;
   logic [2:0] next_summary;

   // Local event status and mask feeding the block interrupt.
   logic [2:0] event_status;
   logic [2:0] event_mask;
   logic [2:0] next_event_status;
   logic [2:0] next_event_mask;
   logic next_block_irq;

   // Register port read path.
   logic [7:0] next_rdata;

   // Decoded strobes.
   logic wr_high_flags;
   logic wr_mid_flags;
   logic wr_low_flags;

   assign wr_high_flags = reg_wr_in &&
      reg_addr_in == irq_agg_pkg::OFFS_HIGH_FLAGS;
   assign wr_mid_flags = reg_wr_in &&
      reg_addr_in == irq_agg_pkg::OFFS_MID_FLAGS;
   assign wr_low_flags = reg_wr_in &&
      reg_addr_in == irq_agg_pkg::OFFS_LOW_FLAGS;

   // Flag update: set only when enabled, clear only on ones written, and
   // the set is applied after the clear so a coincident edge survives.
   always_comb
   begin
      flag_set = edges.rise & enables; // [R03] [R11]
      flag_clear = '0;
      if (wr_high_flags)
         flag_clear[irq_agg_pkg::HIGH_LSB +: 8] = reg_wdata_in; // [R04] [R14]
      if (wr_mid_flags)
         flag_clear[irq_agg_pkg::MID_LSB +: 8] = reg_wdata_in; // [R14]
      if (wr_low_flags)
         flag_clear[irq_agg_pkg::LOW_LSB +: 8] = reg_wdata_in; // [R14]
      // Zero bits in the written byte leave flag_clear low.
      next_flags = (flags & ~flag_clear) | flag_set; // [R04] [R05] [R18]
   end

   // Enable banks are plain read-write storage.
   always_comb
   begin
      next_enables = enables; // [R15]
      if (reg_wr_in)
      begin
         if (reg_addr_in == irq_agg_pkg::OFFS_HIGH_ENABLES)
            next_enables[irq_agg_pkg::HIGH_LSB +: 8] = reg_wdata_in;
         if (reg_addr_in == irq_agg_pkg::OFFS_MID_ENABLES)
            next_enables[irq_agg_pkg::MID_LSB +: 8] = reg_wdata_in;
         if (reg_addr_in == irq_agg_pkg::OFFS_LOW_ENABLES)
            next_enables[irq_agg_pkg::LOW_LSB +: 8] = reg_wdata_in;
      end
   end

   // Code and summary follow the next flags, so they change in the same
   // cycle as the flags and software never sees a stale code.
   always_comb
   begin
      next_priority_code = highest_code(next_flags); // [R08] [R13]
      next_summary = group_any(next_flags); // [R09] [R16]
   end

   // Events: a group event fires when any source of it latches a flag.
   // A read of the status clears it, but a new event in that cycle wins.
   always_comb
   begin
      next_event_status = event_status;
      if (reg_rd_in && reg_addr_in == irq_agg_pkg::OFFS_EVENT_STATUS)
         next_event_status = '0;
      next_event_status = next_event_status | group_any(flag_set);
      next_event_mask = event_mask;
      if (reg_wr_in && reg_addr_in == irq_agg_pkg::OFFS_EVENT_MASK)
         next_event_mask = reg_wdata_in[2:0];
      next_block_irq = |(next_event_status & next_event_mask);
   end

   // Read mux; data stand only in the cycle after the strobe.
   always_comb
   begin
      next_rdata = irq_agg_pkg::UNMAPPED_READ;
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            irq_agg_pkg::OFFS_HIGH_FLAGS:
               next_rdata = flags[irq_agg_pkg::HIGH_LSB +: 8];
            irq_agg_pkg::OFFS_MID_FLAGS:
               next_rdata = flags[irq_agg_pkg::MID_LSB +: 8];
            irq_agg_pkg::OFFS_LOW_FLAGS:
               next_rdata = flags[irq_agg_pkg::LOW_LSB +: 8];
            irq_agg_pkg::OFFS_HIGH_ENABLES:
               next_rdata = enables[irq_agg_pkg::HIGH_LSB +: 8];
            irq_agg_pkg::OFFS_MID_ENABLES:
               next_rdata = enables[irq_agg_pkg::MID_LSB +: 8];
            irq_agg_pkg::OFFS_LOW_ENABLES:
               next_rdata = enables[irq_agg_pkg::LOW_LSB +: 8];
            irq_agg_pkg::OFFS_PRIORITY_CODE:
               next_rdata = priority_code; // [R17]
            irq_agg_pkg::OFFS_LEVEL_SUMMARY:
               next_rdata = {5'h00, summary}; // [R16]
            irq_agg_pkg::OFFS_EVENT_STATUS:
               next_rdata = {5'h00, event_status};
            irq_agg_pkg::OFFS_EVENT_MASK:
               next_rdata = {5'h00, event_mask};
            default:
               next_rdata = irq_agg_pkg::UNMAPPED_READ;
         endcase
      end
   end

   // All state registers; reset returns everything to idle.
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         flags <= '0; // [R07]
         enables <= '0; // [R15]
         priority_code <= irq_agg_pkg::PRIORITY_RESET; // [R17]
         summary <= irq_agg_pkg::SUMMARY_RESET; // [R07]
         event_status <= irq_agg_pkg::EVENT_RESET;
         event_mask <= irq_agg_pkg::EVENT_RESET;
         block_irq_out <= 1'b0;
         reg_rdata_out <= irq_agg_pkg::UNMAPPED_READ;
      end
      else
      begin
         flags <= next_flags;
         enables <= next_enables;
         priority_code <= next_priority_code;
         summary <= next_summary;
         event_status <= next_event_status;
         event_mask <= next_event_mask;
         block_irq_out <= next_block_irq;
         reg_rdata_out <= next_rdata;
      end
   end

   // Each group drives its own level; the processor orders simultaneous
   // levels itself, so high maps to level zero to be served first.
   assign cpu_level_zero_request_out =
      summary[irq_agg_pkg::HIGH_POS]; // [R01] [R02] [R12]
   assign cpu_level_one_request_out =
      summary[irq_agg_pkg::MID_POS]; // [R01] [R12]
   assign cpu_level_two_request_out =
      summary[irq_agg_pkg::LOW_POS]; // [R01] [R12]

   // Checks on the behaviour above.
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);

   chk_level_after_edge: assert property ( // [R12]
      (|flag_set[irq_agg_pkg::HIGH_LSB +: 8]) |=>
         cpu_level_zero_request_out)
      else $error("level zero not raised one cycle after edge");

   chk_low_level_raised: assert property ( // [R01]
      (|flag_set[7:0]) |=> cpu_level_two_request_out &&
         flags[7:0] != 8'h00)
      else $error("low edge did not reach level two");

   chk_disabled_no_set: assert property ( // [R03]
      (!enables[5] && !flags[5]) |=> !flags[5])
      else $error("flag set while its enable was low");

   chk_clear_on_one: assert property ( // [R04]
      (wr_low_flags && reg_wdata_in[0] && !flag_set[0]) |=> !flags[0])
      else $error("write of one did not clear flag");

   chk_zero_keeps: assert property ( // [R05]
      (wr_mid_flags && !reg_wdata_in[3] && flags[11]) |=> flags[11])
      else $error("write of zero changed a flag");

   chk_set_wins_clear: assert property ( // [R18]
      (wr_mid_flags && reg_wdata_in[0] && flag_set[8]) |=> flags[8])
      else $error("coincident edge lost to clear");

   // Every source that rose must be held high in the sampled level after.
   chk_sample_follows_rise: assert property ( // [R10]
      (|edges.rise) |=>
         (edges.level & $past(edges.rise)) == $past(edges.rise))
      else $error("sampled level lost a rising source");

   chk_idle_code: assert property ( // [R08]
      (flags == '0) |-> priority_code == 8'hFF)
      else $error("idle code not 0xFF");

   chk_code_top_source: assert property ( // [R13]
      flags[23] |-> priority_code == 8'h17)
      else $error("code not equal to source number 23");

   chk_summary_ties: assert property ( // [R09]
      summary == {|flags[23:16], |flags[15:8], |flags[7:0]})
      else $error("summary does not follow flags");

   chk_code_read_path: assert property ( // [R17]
      (reg_rd_in && reg_addr_in == irq_agg_pkg::OFFS_PRIORITY_CODE) |=>
         reg_rdata_out == $past(priority_code))
      else $error("priority code read wrong");

   chk_request_held: assert property ( // [R11]
      (cpu_level_one_request_out && !wr_mid_flags) |=>
         cpu_level_one_request_out)
      else $error("level one dropped without a clear");

   cov_high_edge: cover property (
      flag_set[16] ##1 cpu_level_zero_request_out);
   cov_all_levels: cover property (
      cpu_level_zero_request_out && cpu_level_one_request_out &&
      cpu_level_two_request_out);
   cov_clear_retire: cover property (
      cpu_level_one_request_out ##1 wr_mid_flags ##1
      !cpu_level_one_request_out);
   cov_block_irq: cover property (block_irq_out);

endmodule

// >>> verification/irq_cpu_model.sv
`timescale 1ns/100ps
module irq_cpu_model (
   input wire logic sys_clk_in, // Core clock.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic [2:0] levels_in, // Level requests, bit 0 is level zero.
   input wire logic [2:0] retire_in, // Software retire strobes per level.
   output logic [1:0] served_level_out // Level served next, 3 when idle.
);
   logic [2:0] held;
   logic [2:0] next_held;

   // A request stays held in the core until software retires it, so a
   // retire while the request is still high does not lose it.
   always_comb
   begin
      next_held = (held & ~retire_in) | levels_in;
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         held <= 3'h0;
      end
      else
      begin
         held <= next_held;
      end
   end

   // The lowest level number wins when several are held at once.
   always_comb
   begin
      served_level_out = 2'h3;
      if (held[2])
      begin
         served_level_out = 2'h2;
      end
      if (held[1])
      begin
         served_level_out = 2'h1;
      end
      if (held[0])
      begin
         served_level_out = 2'h0;
      end
   end
endmodule

// >>> verification/three_level_irq_aggregator_tb_top.sv
`timescale 1ns/100ps
module three_level_irq_aggregator_tb_top;
   logic sys_clk_in;
   logic resetn_in;
   logic [irq_agg_pkg::NUM_SOURCES-1:0] src;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic lvl0;
   logic lvl1;
   logic lvl2;
   logic block_irq;
   logic [2:0] retire;
   logic [1:0] served;
   int err_count;
   int cmp_count;
   logic [7:0] reset_table [0:15];

   three_level_irq_aggregator three_level_irq_aggregator_inst (
      .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .irq_sources_in(src), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .cpu_level_zero_request_out(lvl0), .cpu_level_one_request_out(lvl1),
      .cpu_level_two_request_out(lvl2), .block_irq_out(block_irq));

   irq_cpu_model irq_cpu_model_inst (
      .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .levels_in({lvl2, lvl1, lvl0}), .retire_in(retire),
      .served_level_out(served));

   // Free-running 100 MHz system clock.
   initial
   begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Each task starts just after a rising edge and ends on one; the idle
   // cycle after a write keeps the strobe from being set twice at one time.
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_in);
      wr <= 1'b0;
      @(posedge sys_clk_in);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_in);
      rd <= 1'b0;
      #1 check(rdata, exp);
      @(posedge sys_clk_in);
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Cuts a hang short; the whole sequence needs well under 400 cycles.
   initial
   begin
      #20000;
      err_count++;
      wrap_up();
   end

   initial
   begin
      err_count = 0;
      cmp_count = 0;
      resetn_in = 1'b0;
      src = '0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      retire = 3'h0;
      foreach (reset_table[i]) reset_table[i] = 8'h00;
      reset_table[irq_agg_pkg::OFFS_PRIORITY_CODE] = 8'hFF;
      repeat (5) @(posedge sys_clk_in);
      resetn_in <= 1'b1;
      @(posedge sys_clk_in);
      // Every offset after reset, unmapped ones included.
      for (int i = 0; i < 16; i++)
         rd_chk(4'(i), reset_table[i]);
      // An edge while disabled is dropped for good.
      src[5] <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      wr_reg(irq_agg_pkg::OFFS_LOW_ENABLES, 8'h20);
      rd_chk(irq_agg_pkg::OFFS_LOW_FLAGS, 8'h00);
      for (int i = 3; i < 6; i++)
      begin
         wr_reg(4'(i), 8'hFF);
         rd_chk(4'(i), 8'hFF);
      end
      // Source 16 rises; its level follows exactly one cycle later.
      src[16] <= 1'b1;
      #1 check({7'h00, lvl0}, 8'h00);
      @(posedge sys_clk_in);
      #1 check({5'h00, lvl2, lvl1, lvl0}, 8'h01);
      @(posedge sys_clk_in);
      rd_chk(irq_agg_pkg::OFFS_HIGH_FLAGS, 8'h01);
      rd_chk(irq_agg_pkg::OFFS_PRIORITY_CODE, 8'h10);
      rd_chk(irq_agg_pkg::OFFS_LEVEL_SUMMARY, 8'h04);
      src[0] <= 1'b1;
      src[8] <= 1'b1;
      src[23] <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      check({5'h00, lvl2, lvl1, lvl0}, 8'h07);
      rd_chk(irq_agg_pkg::OFFS_LEVEL_SUMMARY, 8'h07);
      rd_chk(irq_agg_pkg::OFFS_PRIORITY_CODE, 8'h17);
      check({6'h00, served}, 8'h00);
      // Zeros leave flags alone, ones clear them.
      wr_reg(irq_agg_pkg::OFFS_HIGH_FLAGS, 8'h00);
      rd_chk(irq_agg_pkg::OFFS_HIGH_FLAGS, 8'h81);
      wr_reg(irq_agg_pkg::OFFS_HIGH_FLAGS, 8'h80);
      rd_chk(irq_agg_pkg::OFFS_HIGH_FLAGS, 8'h01);
      rd_chk(irq_agg_pkg::OFFS_PRIORITY_CODE, 8'h10);
      wr_reg(irq_agg_pkg::OFFS_HIGH_FLAGS, 8'h01);
      check({7'h00, lvl0}, 8'h00);
      rd_chk(irq_agg_pkg::OFFS_PRIORITY_CODE, 8'h08);
      retire <= 3'h1;
      @(posedge sys_clk_in);
      retire <= 3'h0;
      @(posedge sys_clk_in);
      check({6'h00, served}, 8'h01);
      // A fresh edge in the cycle of its clear keeps the flag.
      src[8] <= 1'b0;
      @(posedge sys_clk_in);
      src[8] <= 1'b1;
      wr_reg(irq_agg_pkg::OFFS_MID_FLAGS, 8'h01);
      rd_chk(irq_agg_pkg::OFFS_MID_FLAGS, 8'h01);
      wr_reg(irq_agg_pkg::OFFS_MID_FLAGS, 8'h01);
      rd_chk(irq_agg_pkg::OFFS_MID_FLAGS, 8'h00);
      rd_chk(irq_agg_pkg::OFFS_PRIORITY_CODE, 8'h00);
      wr_reg(irq_agg_pkg::OFFS_PRIORITY_CODE, 8'h55);
      rd_chk(irq_agg_pkg::OFFS_PRIORITY_CODE, 8'h00);
      // Event status, mask and the block interrupt line.
      check({7'h00, block_irq}, 8'h00);
      wr_reg(irq_agg_pkg::OFFS_EVENT_MASK, 8'h07);
      check({7'h00, block_irq}, 8'h01);
      rd_chk(irq_agg_pkg::OFFS_EVENT_STATUS, 8'h07);
      rd_chk(irq_agg_pkg::OFFS_EVENT_STATUS, 8'h00);
      check({7'h00, block_irq}, 8'h00);
      // A reset in mid-run clears flags and levels at once.
      resetn_in <= 1'b0;
      @(posedge sys_clk_in);
      #1 check({5'h00, lvl2, lvl1, lvl0}, 8'h00);
      @(posedge sys_clk_in);
      resetn_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_chk(irq_agg_pkg::OFFS_LOW_FLAGS, 8'h00);
      rd_chk(irq_agg_pkg::OFFS_PRIORITY_CODE, 8'hFF);
      wrap_up();
   end
endmodule
